// >>> inc/tcc_pkg.sv
// Purpose: shared constants and types of the timer counter control core
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes: registers hold byte-wide data in bits 7:0, modulo value 16 bits in 15:0; upper bits read zero
package tcc_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] TCC_ADDR_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] TCC_ADDR_COUNTER_HIGH = 8'h04;
	localparam logic [7:0] TCC_ADDR_COUNTER_LOW = 8'h08;
	localparam logic [7:0] TCC_ADDR_MODULO_VALUE = 8'h0c;
	localparam int TCC_ADDR_W = 8;

	// ************************************************************
	// status/control field positions
	// ************************************************************
	localparam int TCC_BIT_OVERFLOW_FLAG = 7;
	localparam int TCC_BIT_OVERFLOW_IRQ_ENABLE = 6;
	localparam int TCC_BIT_CENTER_ALIGNED = 5;
	localparam int TCC_BIT_CLKS_HI = 4;
	localparam int TCC_BIT_CLKS_LO = 3;
	localparam int TCC_BIT_PS_HI = 2;
	localparam int TCC_BIT_PS_LO = 0;

	// ************************************************************
	// reset values, counter top and unmapped read value
	// ************************************************************
	localparam logic [15:0] TCC_COUNTER_RESET = 16'h0000;
	localparam logic [15:0] TCC_MODULO_RESET = 16'h0000;
	localparam logic [15:0] TCC_COUNTER_TOP = 16'hffff;
	localparam logic [6:0] TCC_PRESCALE_RESET = 7'h00;
	localparam logic [31:0] TCC_UNMAPPED_READ = 32'h0000_0000;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [1:0] {
		TCC_CLK_OFF = 2'h0,
		TCC_CLK_BUS = 2'h1,
		TCC_CLK_FIXED = 2'h2,
		TCC_CLK_EXT = 2'h3
	} tcc_clk_src_t;

	typedef struct packed {
		logic overflow_irq_enable;
		logic center_aligned_select;
		tcc_clk_src_t clock_source_select;
		logic [2:0] prescale_select;
	} tcc_ctrl_t;

	localparam tcc_ctrl_t TCC_CTRL_RESET = '{1'b0, 1'b0, TCC_CLK_OFF, 3'h0};

	typedef struct packed {
		logic [15:0] value;
		logic count_down;
		logic overflow_flag;
	} tcc_status_t;

endpackage : tcc_pkg

// >>> logic/tcc_core.sv
// Purpose: control and counter core of a 16-bit timer/PWM module
// Assumes: AHB-Lite slave, zero wait states, word accesses
// Notes: channel logic sits outside and reads counter_value and count_down
// Contract
// - overflow flag sets when counter wraps to zero after modulo value
// - flag clears only by status read while set, then writing zero
// - overflow between that read and write restarts clear sequence
// - reset clears flag; writing one to flag changes nothing
// - interrupt request while flag and enable both set; enable resets clear
// - center-aligned bit selects up/down counting; cleared by reset
// - two-bit source field: off, bus, fixed system, external clock
// - external source synchronized to bus clock inside this block
// - fixed clock without active PLL/FLL behaves as bus clock
// - prescale field divides selected clock by two to the field
// - prescaler follows source selection and synchronization
// - new prescale value acts on the cycle after register update
// - reading either counter byte latches both until other is read
// - reset or any status/control write restarts the read latch
// - reset clears counter; any counter byte write clears it and latch
// - during debug counter stops and reads return frozen value
// - during debug counter reads leave the read latch untouched
// - during debug status or counter writes still reset the latch
// - after reaching modulo counter resumes from zero next count; in center-aligned mode it counts down instead
// - modulo of zero makes counter free-run over full range
//
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module tcc_core
	import tcc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic ext_clk_pin,
	input wire logic fixed_clk_tick,
	input wire logic pll_fll_active,
	input wire logic background_debug_active,
	output logic overflow_irq,
	output logic center_aligned_select,
	output logic [15:0] counter_value,
	output logic count_down
);

	// ************************************************************
	// bus address phase capture
	// ************************************************************
	logic addr_valid;
	logic [TCC_ADDR_W-1:0] addr_low;
	logic rd_now;
	logic wr_phase_q;
	logic [TCC_ADDR_W-1:0] wr_addr_q;

	assign addr_valid = hsel && htrans[1] && hready;
	assign addr_low = haddr[TCC_ADDR_W-1:0];
	assign rd_now = addr_valid && !hwrite;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_phase_q <= 1'b0;
			wr_addr_q <= '0;
		end else if (clk_en) begin
			wr_phase_q <= addr_valid && hwrite;
			wr_addr_q <= addr_low;
		end
	end

	// ************************************************************
	// access decode
	// ************************************************************
	logic rd_sc;
	logic rd_cnth;
	logic rd_cntl;
	logic rd_mod;
	logic wr_sc;
	logic wr_cnt;
	logic wr_mod;

	assign rd_sc = rd_now && (addr_low == TCC_ADDR_STATUS_CONTROL);
	assign rd_cnth = rd_now && (addr_low == TCC_ADDR_COUNTER_HIGH);
	assign rd_cntl = rd_now && (addr_low == TCC_ADDR_COUNTER_LOW);
	assign rd_mod = rd_now && (addr_low == TCC_ADDR_MODULO_VALUE);
	// write data only exists in the data phase, so writes act one cycle late
	assign wr_sc = wr_phase_q && (wr_addr_q == TCC_ADDR_STATUS_CONTROL);
	assign wr_cnt = wr_phase_q && ((wr_addr_q == TCC_ADDR_COUNTER_HIGH)
		|| (wr_addr_q == TCC_ADDR_COUNTER_LOW));
	assign wr_mod = wr_phase_q && (wr_addr_q == TCC_ADDR_MODULO_VALUE);

	// ************************************************************
	// control register
	// ************************************************************
	tcc_ctrl_t ctrl_q;
	tcc_ctrl_t ctrl_d;
	logic [15:0] modulo_q;

	assign ctrl_d = wr_sc ? tcc_ctrl_t'(hwdata[TCC_BIT_OVERFLOW_IRQ_ENABLE:TCC_BIT_PS_LO]) : ctrl_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= TCC_CTRL_RESET;
			modulo_q <= TCC_MODULO_RESET;
		end else if (clk_en) begin
			ctrl_q <= ctrl_d;
			if (wr_mod) begin
				modulo_q <= hwdata[15:0];
			end
		end
	end

	assign center_aligned_select = ctrl_q.center_aligned_select;

	// ************************************************************
	// external clock synchronizer
	// ************************************************************
	logic ext_meta_q;
	logic ext_sync_q;
	logic ext_prev_q;
	logic ext_rise;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_meta_q <= 1'b0;
			ext_sync_q <= 1'b0;
			ext_prev_q <= 1'b0;
		end else if (clk_en) begin
			ext_meta_q <= ext_clk_pin;
			ext_sync_q <= ext_meta_q;
			ext_prev_q <= ext_sync_q;
		end
	end

	// edges closer than two bus clocks may be missed
	assign ext_rise = ext_sync_q && !ext_prev_q;

	// ************************************************************
	// source selection and prescaler
	// ************************************************************
	logic src_tick;
	logic src_run;
	logic count_tick;

	// fixed clock falls back to bus rate
	assign src_tick = (ctrl_q.clock_source_select == TCC_CLK_BUS) ? 1'b1
		: (ctrl_q.clock_source_select == TCC_CLK_FIXED)
			? (pll_fll_active ? fixed_clk_tick : 1'b1)
		: (ctrl_q.clock_source_select == TCC_CLK_EXT) ? ext_rise
		: 1'b0;
	assign src_run = (ctrl_q.clock_source_select != TCC_CLK_OFF) && !background_debug_active;

	// divide by two to the field
	tcc_prescaler u_prescaler (
		.hclk(hclk),
		.hresetn(hresetn),
		.clk_en(clk_en),
		.run(src_run),
		.in_tick(src_tick),
		.prescale_select(ctrl_q.prescale_select),
		.out_tick(count_tick)
	);

	// ************************************************************
	// counter
	// ************************************************************
	tcc_status_t cnt_q;
	tcc_status_t cnt_d;
	logic [15:0] top;
	logic at_top;
	logic overflow_event;
	logic armed_q;
	logic armed_d;

	assign top = (modulo_q == TCC_MODULO_RESET) ? TCC_COUNTER_TOP : modulo_q;
	assign at_top = (cnt_q.value == top);

	// wrap or return to zero marks overflow
	assign overflow_event = count_tick && (ctrl_q.center_aligned_select
		? (cnt_q.count_down && (cnt_q.value == 16'h0001))
		: at_top);

	always_comb begin
		cnt_d = cnt_q;
		if (count_tick) begin
			if (!ctrl_q.center_aligned_select) begin
				cnt_d.count_down = 1'b0;
				cnt_d.value = at_top ? TCC_COUNTER_RESET : cnt_q.value + 16'h0001;
			end else if (!cnt_q.count_down) begin
				if (at_top) begin
					cnt_d.count_down = 1'b1;
					cnt_d.value = cnt_q.value - 16'h0001;
				end else begin
					cnt_d.value = cnt_q.value + 16'h0001;
				end
			end else begin
				if (cnt_q.value == 16'h0001) begin
					cnt_d.count_down = 1'b0;
				end
				cnt_d.value = cnt_q.value - 16'h0001;
			end
		end
		if (wr_cnt) begin
			cnt_d.value = TCC_COUNTER_RESET;
			cnt_d.count_down = 1'b0;
		end
		// clear only after an armed read
		if (wr_sc && !hwdata[TCC_BIT_OVERFLOW_FLAG] && armed_q) begin
			cnt_d.overflow_flag = 1'b0;
		end
		// set beats a simultaneous clear
		if (overflow_event) begin
			cnt_d.overflow_flag = 1'b1;
		end
	end

	// a new overflow disarms the pending clear
	always_comb begin
		armed_d = armed_q;
		if (wr_sc) begin
			armed_d = 1'b0;
		end
		if (rd_sc && cnt_q.overflow_flag) begin
			armed_d = 1'b1;
		end
		if (overflow_event) begin
			armed_d = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= '{TCC_COUNTER_RESET, 1'b0, 1'b0};
			armed_q <= 1'b0;
		end else if (clk_en) begin
			cnt_q <= cnt_d;
			armed_q <= armed_d;
		end
	end

	assign counter_value = cnt_q.value;
	assign count_down = cnt_q.count_down;
	assign overflow_irq = cnt_q.overflow_flag && ctrl_q.overflow_irq_enable;

	// ************************************************************
	// counter read coherency latch
	// ************************************************************
	logic latched_q;
	logic latched_d;
	logic first_high_q;
	logic first_high_d;
	logic [15:0] snap_q;
	logic [15:0] snap_d;
	logic [15:0] read_view;

	// a read after a counter write sees the cleared count; the byte
	// returned always comes from the same value that the latch keeps
	assign read_view = (latched_q && !(wr_sc || wr_cnt)) ? snap_q
		: (wr_cnt ? TCC_COUNTER_RESET : cnt_q.value);

	always_comb begin
		latched_d = latched_q;
		first_high_d = first_high_q;
		snap_d = snap_q;
		if (wr_sc || wr_cnt) begin
			latched_d = 1'b0;
		end
		// debug reads do not move the latch
		if (!background_debug_active && (rd_cnth || rd_cntl)) begin
			// first byte read captures both halves
			if (!latched_d) begin
				latched_d = 1'b1;
				first_high_d = rd_cnth;
				snap_d = read_view;
			end else if (rd_cnth != first_high_q) begin
				latched_d = 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			latched_q <= 1'b0;
			first_high_q <= 1'b0;
			snap_q <= TCC_COUNTER_RESET;
		end else if (clk_en) begin
			latched_q <= latched_d;
			first_high_q <= first_high_d;
			snap_q <= snap_d;
		end
	end

	// ************************************************************
	// read data
	// ************************************************************
	logic [7:0] sc_byte;
	logic [31:0] rdata_d;
	logic [31:0] rdata_q;

	assign sc_byte = {cnt_q.overflow_flag, ctrl_q};

	// byte data in low lane, one cycle answer
	assign rdata_d = rd_sc ? {24'h000000, sc_byte}
		: rd_cnth ? {24'h000000, read_view[15:8]}
		: rd_cntl ? {24'h000000, read_view[7:0]}
		: rd_mod ? {16'h0000, modulo_q}
		: TCC_UNMAPPED_READ;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q <= TCC_UNMAPPED_READ;
		end else if (clk_en && rd_now) begin
			rdata_q <= rdata_d;
		end
	end

	assign hrdata = rdata_q;

	// hsize is not checked: every access is treated as a full word
	logic unused_size;
	assign unused_size = ^{hsize, haddr[31:TCC_ADDR_W]};

endmodule : tcc_core
`default_nettype wire

// >>> logic/tcc_prescaler.sv
// Purpose: divide a stream of source ticks by two to the power of a select
// Assumes: in_tick is one-cycle pulses on hclk
// Notes: counter restarts whenever the source is stopped
`timescale 1ns/100ps
`default_nettype none
module tcc_prescaler
	import tcc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic run,
	input wire logic in_tick,
	input wire logic [2:0] prescale_select,
	output logic out_tick
);

	logic [6:0] div_q;
	logic [6:0] div_d;
	logic [6:0] mask;

	// mask of the low bits that must all be one before a tick passes
	assign mask = 7'((8'h01 << prescale_select) - 8'h01);
	assign out_tick = run && in_tick && ((div_q & mask) == mask);
	assign div_d = !run ? TCC_PRESCALE_RESET : (in_tick ? div_q + 7'h01 : div_q);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_q <= TCC_PRESCALE_RESET;
		end else if (clk_en) begin
			div_q <= div_d;
		end
	end

endmodule : tcc_prescaler
`default_nettype wire

// >>> test/tcc_ahb_host.sv
// Purpose: processor side of the register bus, single word transfers
// Assumes: one slave, its hreadyout is hready
// Notes: released address and data lines show inverted last value
`timescale 1ns/100ps
`default_nettype none
module tcc_ahb_host
	import tcc_pkg::*;
(
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// one byte register per single transfer
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		haddr <= ~haddr;
		hwdata <= w ? wd : ~hwdata;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
		hwdata <= ~hwdata;
	endtask : xfer
endmodule : tcc_ahb_host
`default_nettype wire

// >>> test/tcc_core_chk.sv
// Purpose: port-level checks of the timer counter control core
// Assumes: zero-wait slave, no bus traffic while clk_en is low
// Notes: bound to every tcc_core instance
`timescale 1ns/100ps
`default_nettype none
module tcc_core_chk
	import tcc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic background_debug_active,
	input wire logic overflow_irq,
	input wire logic center_aligned_select,
	input wire logic [15:0] counter_value,
	input wire logic count_down
);
	// ****
	// data-phase trackers
	// ****
	logic take;
	logic hit_cnt;
	logic wsc_q;
	logic wcnt_q;
	assign take = hsel & htrans[1] & hready;
	assign hit_cnt = haddr[7:0] == TCC_ADDR_COUNTER_HIGH || haddr[7:0] == TCC_ADDR_COUNTER_LOW;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wsc_q <= 1'b0;
			wcnt_q <= 1'b0;
		end else begin
			wsc_q <= take & hwrite & (haddr[7:0] == TCC_ADDR_STATUS_CONTROL);
			wcnt_q <= take & hwrite & hit_cnt;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	ready_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	rdata_hold_a: assert property ($changed(hrdata) |-> $past(take && !hwrite))
		else $error("read data moved without a read");
	irq_source_a: assert property ($rose(overflow_irq) && !$past(wsc_q) |-> counter_value == 16'h0000)
		else $error("overflow request away from zero");
	irq_drop_a: assert property ($fell(overflow_irq) |-> $past(wsc_q))
		else $error("overflow request dropped without a control write");
	cnt_clear_a: assert property (wcnt_q |=> counter_value == 16'h0000)
		else $error("counter not cleared by a write");
	dbg_freeze_a: assert property (background_debug_active && $past(background_debug_active)
		&& !$past(wcnt_q) |-> $stable(counter_value))
		else $error("counter moved in debug");
	step_size_a: assert property ($changed(counter_value) |-> counter_value == 16'h0000
		|| counter_value == $past(counter_value) + 16'h0001
		|| counter_value == $past(counter_value) - 16'h0001)
		else $error("counter jumped");
	up_only_a: assert property (!center_aligned_select && !$past(center_aligned_select)
		&& $changed(counter_value) |-> counter_value == 16'h0000
		|| counter_value == $past(counter_value) + 16'h0001)
		else $error("counter went down in up mode");
	down_step_a: assert property (center_aligned_select && $past(center_aligned_select)
		&& $past(count_down) && $past(counter_value) != 16'h0000 && !$past(wcnt_q)
		&& $changed(counter_value) |-> counter_value == $past(counter_value) - 16'h0001)
		else $error("down count not stepping by one");
	cover property ($rose(overflow_irq));
	cover property ($rose(count_down));
	cover property (background_debug_active && wcnt_q);
endmodule : tcc_core_chk
bind tcc_core tcc_core_chk tcc_core_chk_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hready, .hrdata, .hreadyout, .hresp, .background_debug_active, .overflow_irq,
	.center_aligned_select, .counter_value, .count_down);
`default_nettype wire

// >>> test/testbench.sv
// Purpose: self-checking bench of the timer counter control core
// Assumes: zero-wait slave, clk_en low only in its own scenario
// Notes: count windows allow for sync delay and prescaler phase
`timescale 1ns/100ps
`default_nettype none
module testbench
	import tcc_pkg::*;
;
	localparam logic [7:0] A_SC = TCC_ADDR_STATUS_CONTROL;
	localparam logic [7:0] A_CH = TCC_ADDR_COUNTER_HIGH;
	localparam logic [7:0] A_CL = TCC_ADDR_COUNTER_LOW;
	localparam logic [7:0] A_MOD = TCC_ADDR_MODULO_VALUE;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic clk_en = 1'b1;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic ext_clk_pin = 1'b0;
	logic fixed_clk_tick = 1'b0;
	logic pll_fll_active = 1'b0;
	logic background_debug_active = 1'b0;
	logic overflow_irq;
	logic center_aligned_select;
	logic [15:0] counter_value;
	logic count_down;
	logic [7:0] cyc_q = 8'h00;
	int err_total = 0;
	int n_checks = 0;
	always #50 hclk = ~hclk;
	// ext source at an eighth of bus rate, fixed tick at a quarter
	always @(posedge hclk) begin
		cyc_q <= cyc_q + 8'h01;
		ext_clk_pin <= cyc_q[2];
		fixed_clk_tick <= cyc_q[1:0] == 2'h3;
	end
	tcc_core tcc_core_i (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_clk_pin, .fixed_clk_tick,
		.pll_fll_active, .background_debug_active, .overflow_irq, .center_aligned_select,
		.counter_value, .count_down);
	tcc_ahb_host tcc_ahb_host_i (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic chkr(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
		n_checks++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask : chkr
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] x;
		tcc_ahb_host_i.xfer(1'b1, a, {24'h0, d}, x);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		tcc_ahb_host_i.xfer(1'b0, a, 32'h0, v);
	endtask : rd
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		rd(a, v);
		chk(v, e);
	endtask : rc
	task automatic t_reset;
		rc(A_SC, 32'h0);
		rc(A_CH, 32'h0);
		rc(A_CL, 32'h0);
		rc(A_MOD, 32'h0);
		wr(8'h10, 8'hff);
		rc(8'h10, 32'h0);
		@(negedge hclk);
		chk({31'h0, center_aligned_select}, 32'h0);
		chk({31'h0, overflow_irq}, 32'h0);
	endtask : t_reset
	// clear, run 512 cycles, read both bytes
	task automatic t_rate(input logic [7:0] sc, input logic [15:0] e);
		logic [31:0] lo;
		logic [31:0] hi;
		wr(A_SC, sc);
		wr(A_CH, 8'h5a);
		repeat (512) @(posedge hclk);
		rd(A_CL, lo);
		rd(A_CH, hi);
		chkr({hi[7:0], lo[7:0]}, (e == 16'h0) ? e : e - 16'h1, (e == 16'h0) ? e : e + 16'h4);
	endtask : t_rate
	task automatic t_coherent;
		logic [31:0] v;
		wr(A_SC, 8'h08);
		wr(A_CL, 8'ha5);
		repeat (600) @(posedge hclk);
		rd(A_CL, v);
		chkr({8'h02, v[7:0]}, 16'h0255, 16'h0262);
		repeat (300) @(posedge hclk);
		rc(A_CH, 32'h02);
		rc(A_CH, 32'h03);
		rd(A_CL, v);
		rd(A_CL, v);
		wr(A_SC, 8'h08);
		repeat (300) @(posedge hclk);
		rc(A_CH, 32'h04);
	endtask : t_coherent
	task automatic t_overflow;
		wr(A_MOD, 8'h0f);
		wr(A_SC, 8'h48);
		wr(A_CH, 8'h00);
		repeat (40) @(negedge hclk);
		chk({31'h0, overflow_irq}, 32'h1);
		rc(A_SC, 32'hc8);
		repeat (40) @(posedge hclk);
		wr(A_SC, 8'h48);
		wr(A_SC, 8'h80);
		@(negedge hclk);
		chk({31'h0, overflow_irq}, 32'h0);
		rc(A_SC, 32'h80);
		wr(A_SC, 8'h00);
		rc(A_SC, 32'h00);
		wr(A_MOD, 8'h00);
	endtask : t_overflow
	task automatic t_debug;
		logic [31:0] v;
		wr(A_SC, 8'h08);
		wr(A_CH, 8'h00);
		repeat (300) @(posedge hclk);
		rd(A_CL, v);
		repeat (300) @(posedge hclk);
		background_debug_active <= 1'b1;
		rd(A_CH, v);
		rd(A_CL, v);
		repeat (50) @(posedge hclk);
		rc(A_CL, v);
		background_debug_active <= 1'b0;
		rc(A_CH, 32'h01);
		// latch again so the debug write has a latch to drop
		rd(A_CL, v);
		background_debug_active <= 1'b1;
		wr(A_CL, 8'h33);
		rc(A_CL, 32'h0);
		background_debug_active <= 1'b0;
	endtask : t_debug
	task automatic t_center;
		logic [15:0] mx = 16'h0;
		logic dn = 1'b0;
		wr(A_MOD, 8'h04);
		wr(A_SC, 8'h28);
		wr(A_CH, 8'h00);
		repeat (24) begin
			@(negedge hclk);
			if (counter_value > mx) mx = counter_value;
			if (count_down === 1'b1 && counter_value == 16'h0003) dn = 1'b1;
		end
		chk({16'h0, mx}, 32'h4);
		chk({31'h0, dn}, 32'h1);
		chk({31'h0, center_aligned_select}, 32'h1);
		wr(A_SC, 8'h00);
	endtask : t_center
	// clock enable low must hold the counter, high must release it
	task automatic t_freeze;
		logic [15:0] c;
		wr(A_SC, 8'h08);
		repeat (20) @(posedge hclk);
		clk_en <= 1'b0;
		@(negedge hclk);
		c = counter_value;
		repeat (20) @(negedge hclk);
		chk({16'h0, counter_value}, {16'h0, c});
		@(posedge hclk);
		clk_en <= 1'b1;
		repeat (2) @(negedge hclk);
		chk({31'h0, (counter_value != c)}, 32'h1);
		wr(A_SC, 8'h00);
	endtask : t_freeze
	task automatic end_of_test;
		$display("checks=%0d errors=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		for (int p = 0; p < 8; p++) begin
			t_rate(8'h08 | 8'(p), 16'(512 >> p));
		end
		t_rate(8'h10, 16'h0200);
		pll_fll_active <= 1'b1;
		t_rate(8'h10, 16'h0080);
		t_rate(8'h18, 16'h0040);
		t_rate(8'h1a, 16'h0010);
		t_rate(8'h00, 16'h0000);
		t_coherent;
		t_overflow;
		t_debug;
		t_center;
		t_freeze;
		end_of_test;
	end
	// hang guard, about twice the expected run
	initial begin
		repeat (20000) @(posedge hclk);
		err_total++;
		end_of_test;
	end
endmodule : testbench
`default_nettype wire
